// file: rtl/bist_pattern_consts.vh
// constants for the power-delivery phy self-test pattern unit
`ifndef BIST_PATTERN_CONSTS_VH
`define BIST_PATTERN_CONSTS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   20
`define BIT_PERIOD_NS   3333
`define BIT_DIV_CYCLES  (`BIT_PERIOD_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// pseudo-random sequence and frame layout
// ----------------------------------------------------------------
`define PRBS_SEED       8'hFF
`define PRE_LAST        10'h03F
`define SOP_PATTERN     20'h8E318
`define SOP_LAST        10'h013
`define PAY_LAST        10'h3FF
`define MIN_FRAMES      16
`define MIN_FRAMES_DEF  16'h1196
`define ERR_MAX         16'hFFFF

// ----------------------------------------------------------------
// test modes
// ----------------------------------------------------------------
`define MODE_RX         3'h0
`define MODE_TX         3'h1
`define MODE_EYE        3'h2
`define MODE_CARR0      3'h3
`define MODE_CARR1      3'h4
`define MODE_CARR2      3'h5
`define MODE_CARR3      3'h6
`define MASK_BMC_REQ    8'h20
`define MASK_FSK_REQ    8'h65
`define MODE_MASK_DEF   8'h7F

`endif

// file: rtl/pd_phy_bist_pattern_unit.v
// self-test pattern generator, test frame builder and bit-error checker
// How it works
// - generator and checker use 8-stage register with x^8+x^6+x^5+x^4+1.
// - all eight stages are loaded with one before use.
// - the all-ones load happens when the test-mode request arrives.
// - frame is raw preamble, 4b5b start ordered set, 1024 raw payload bits.
// - generator state carries across frames as one unbroken stream.
// - frames are fixed length; only hard reset is recognised, ending test mode.
// - transmitter sends at least the confidence count of frames.
// - transmitter ends the frame sequence by issuing hard reset.
// - unit under test keeps a running bit-error count while receiving.
// - carrier mode 0 sends zeros until test mode ends.
// - carrier mode 1 sends ones until test mode ends.
// - carrier mode 2 alternates one and zero every bit.
// - carrier mode 3 repeats sixteen ones then sixteen zeros.
// - eye pattern sends the pseudo-random stream with no frame boundaries.
// - mode support follows the signaling schemes the device supports.
`include "bist_pattern_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module pd_phy_bist_pattern_unit #(
	parameter [15:0] MIN_TEST_FRAME_COUNT = `MIN_FRAMES_DEF,
	parameter [7:0]  MODE_MASK            = `MODE_MASK_DEF,
	parameter        SUPPORT_BMC          = 1,
	parameter        SUPPORT_FSK          = 0,
	parameter [15:0] BIT_DIV              = `BIT_DIV_CYCLES
) (
	// clock and reset
	input  wire        CLK_SYS,
	input  wire        RST,
	// test-mode control
	input  wire        TEST_REQ,
	input  wire [2:0]  TEST_MODE,
	input  wire        HARD_RESET_DET,
	// receive bit stream from the phy
	input  wire        RX_BIT,
	input  wire        RX_BIT_STB,
	input  wire        RX_PAYLOAD,
	// transmit bit stream to the phy
	output reg         TX_BIT,
	output reg         TX_EN,
	output reg         HARD_RESET_SEND,
	// status
	output reg         TEST_ACTIVE,
	output reg  [2:0]  ACTIVE_MODE,
	output reg  [15:0] FRAME_COUNT,
	output reg         CONFIDENCE_MET,
	output reg  [15:0] SELFTEST_ERROR_TALLY
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_PRE  = 3'h1;
	localparam [2:0] ST_SOP  = 3'h2;
	localparam [2:0] ST_PAY  = 3'h3;
	localparam [2:0] ST_CONT = 3'h4;
	localparam [2:0] ST_RECV = 3'h5;
	localparam [2:0] ST_HRST = 3'h6;

	// modes the signaling scheme makes mandatory are always accepted
	localparam [7:0] REQ_MASK = (SUPPORT_BMC ? `MASK_BMC_REQ : 8'h00) |
		(SUPPORT_FSK ? `MASK_FSK_REQ : 8'h00);
	localparam [7:0] OK_MASK = MODE_MASK | REQ_MASK;
	localparam [19:0] SOP_WORD = `SOP_PATTERN;

	// ----------------------------------------------------------------
	// sequence step
	// ----------------------------------------------------------------
	function [7:0] prbs_next;
		input [7:0] s;
		begin
			prbs_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
		end
	endfunction

	// ----------------------------------------------------------------
	// frame goal
	// ----------------------------------------------------------------
	function goal_hit;
		input [15:0] cnt;
		begin
			goal_hit = (cnt + 16'h0001 >= MIN_TEST_FRAME_COUNT);
		end
	endfunction

	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [2:0]  mode_q;
	reg  [7:0]  gen_q;
	reg  [7:0]  gen_d;
	reg  [7:0]  chk_q;
	reg  [9:0]  idx_q;
	reg  [9:0]  idx_d;
	reg  [4:0]  run_q;
	reg  [4:0]  run_d;
	reg         alt_q;
	reg         alt_d;
	reg  [15:0] div_q;
	reg         tick_q;
	reg         tx_bit_d;
	reg         tx_en_d;
	reg         frame_done;
	wire        mode_ok;
	wire        start;
	wire        hrst_go;

	// unsupported modes are refused with no sign at the ports
	assign mode_ok = OK_MASK[TEST_MODE];
	assign start   = TEST_REQ && mode_ok && !TEST_ACTIVE;
	assign hrst_go = (state_q == ST_HRST) && tick_q;

	// ----------------------------------------------------------------
	// bit-rate divider
	// ----------------------------------------------------------------
	// restarts at entry so the first bit gets a full period
	always @(posedge CLK_SYS) begin
		if (RST || start) begin
			div_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_q == BIT_DIV - 16'h0001) begin
			div_q  <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// transmit sequencing
	// ----------------------------------------------------------------
	always @* begin
		state_d    = state_q;
		gen_d      = gen_q;
		idx_d      = idx_q;
		run_d      = run_q;
		alt_d      = alt_q;
		tx_bit_d   = TX_BIT;
		tx_en_d    = TX_EN;
		frame_done = 1'b0;
		case (state_q)
			ST_IDLE: begin
				tx_en_d  = 1'b0;
				tx_bit_d = 1'b0;
			end
			ST_PRE: if (tick_q) begin
				tx_en_d  = 1'b1;
				tx_bit_d = idx_q[0];
				idx_d    = idx_q + 10'h001;
				if (idx_q == `PRE_LAST) begin
					state_d = ST_SOP;
					idx_d   = 10'h000;
				end
			end
			ST_SOP: if (tick_q) begin
				tx_bit_d = SOP_WORD[idx_q[4:0]];
				idx_d    = idx_q + 10'h001;
				if (idx_q == `SOP_LAST) begin
					state_d = ST_PAY;
					idx_d   = 10'h000;
				end
			end
			ST_PAY: if (tick_q) begin
				tx_bit_d = gen_q[7];
				gen_d    = prbs_next(gen_q);
				idx_d    = idx_q + 10'h001;
				if (idx_q == `PAY_LAST) begin
					frame_done = 1'b1;
					idx_d      = 10'h000;
					if (goal_hit(FRAME_COUNT))
						state_d = ST_HRST;
					else
						state_d = ST_PRE;
				end
			end
			ST_CONT: if (tick_q) begin
				tx_en_d = 1'b1;
				case (mode_q)
					`MODE_CARR0: tx_bit_d = 1'b0;
					`MODE_CARR1: tx_bit_d = 1'b1;
					`MODE_CARR2: begin
						tx_bit_d = alt_q;
						alt_d    = ~alt_q;
					end
					`MODE_CARR3: begin
						tx_bit_d = ~run_q[4];
						run_d    = run_q + 5'h01;
					end
					`MODE_EYE: begin
						tx_bit_d = gen_q[7];
						gen_d    = prbs_next(gen_q);
					end
					default: tx_bit_d = 1'b0;
				endcase
			end
			ST_RECV: begin
				tx_en_d  = 1'b0;
				tx_bit_d = 1'b0;
			end
			ST_HRST: if (tick_q) begin
				// last payload bit keeps its full period before the line drops
				tx_en_d  = 1'b0;
				tx_bit_d = 1'b0;
				state_d  = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// state, generator and status registers
	// ----------------------------------------------------------------
	always @(posedge CLK_SYS) begin
		if (RST) begin
			state_q         <= ST_IDLE;
			mode_q          <= `MODE_RX;
			gen_q           <= `PRBS_SEED;
			idx_q           <= 10'h000;
			run_q           <= 5'h00;
			alt_q           <= 1'b1;
			TX_BIT          <= 1'b0;
			TX_EN           <= 1'b0;
			HARD_RESET_SEND <= 1'b0;
			TEST_ACTIVE     <= 1'b0;
			ACTIVE_MODE     <= `MODE_RX;
			FRAME_COUNT     <= 16'h0000;
			CONFIDENCE_MET  <= 1'b0;
		end else if (TEST_ACTIVE && HARD_RESET_DET) begin
			// hard reset beats every event but RST in this block; the receive checker still takes a payload bit in that cycle
			state_q         <= ST_IDLE;
			TX_BIT          <= 1'b0;
			TX_EN           <= 1'b0;
			HARD_RESET_SEND <= 1'b0;
			TEST_ACTIVE     <= 1'b0;
		end else if (start) begin
			// both shift registers restart from all ones on every entry
			gen_q           <= `PRBS_SEED;
			idx_q           <= 10'h000;
			run_q           <= 5'h00;
			alt_q           <= 1'b1;
			mode_q          <= TEST_MODE;
			ACTIVE_MODE     <= TEST_MODE;
			TEST_ACTIVE     <= 1'b1;
			FRAME_COUNT     <= 16'h0000;
			CONFIDENCE_MET  <= 1'b0;
			HARD_RESET_SEND <= 1'b0;
			TX_BIT          <= 1'b0;
			TX_EN           <= 1'b0;
			if (TEST_MODE == `MODE_TX)
				state_q <= ST_PRE;
			else if (TEST_MODE == `MODE_RX)
				state_q <= ST_RECV;
			else
				state_q <= ST_CONT;
		end else begin
			state_q         <= state_d;
			gen_q           <= gen_d;
			idx_q           <= idx_d;
			run_q           <= run_d;
			alt_q           <= alt_d;
			TX_BIT          <= tx_bit_d;
			TX_EN           <= tx_en_d;
			HARD_RESET_SEND <= hrst_go;
			if (hrst_go)
				TEST_ACTIVE <= 1'b0;
			if (frame_done) begin
				FRAME_COUNT <= FRAME_COUNT + 16'h0001;
				if (goal_hit(FRAME_COUNT))
					CONFIDENCE_MET <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive checker
	// ----------------------------------------------------------------
	always @(posedge CLK_SYS) begin
		if (RST) begin
			chk_q                <= `PRBS_SEED;
			SELFTEST_ERROR_TALLY <= 16'h0000;
		end else if (start) begin
			chk_q                <= `PRBS_SEED;
			SELFTEST_ERROR_TALLY <= 16'h0000;
		end else if (state_q == ST_RECV && RX_BIT_STB && RX_PAYLOAD) begin
			// only payload bits step the checker
			chk_q <= prbs_next(chk_q);
			// saturate so a very long run never wraps back to clean
			if (RX_BIT != chk_q[7] && SELFTEST_ERROR_TALLY != `ERR_MAX)
				SELFTEST_ERROR_TALLY <= SELFTEST_ERROR_TALLY + 16'h0001;
		end
	end

endmodule

`default_nettype wire

// file: verification/pd_bist_asserts.sv
// port-level checks for the self-test pattern unit
`include "bist_pattern_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pd_bist_asserts #(
	parameter [15:0] MIN_TEST_FRAME_COUNT = `MIN_FRAMES_DEF
) (
	// clock, reset and control
	input wire logic        CLK_SYS,
	input wire logic        RST,
	input wire logic        TEST_REQ,
	input wire logic [2:0]  TEST_MODE,
	input wire logic        HARD_RESET_DET,
	input wire logic        RX_BIT,
	input wire logic        RX_BIT_STB,
	input wire logic        RX_PAYLOAD,
	// outputs
	input wire logic        TX_BIT,
	input wire logic        TX_EN,
	input wire logic        HARD_RESET_SEND,
	input wire logic        TEST_ACTIVE,
	input wire logic [2:0]  ACTIVE_MODE,
	input wire logic [15:0] FRAME_COUNT,
	input wire logic        CONFIDENCE_MET,
	input wire logic [15:0] SELFTEST_ERROR_TALLY
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	AST_ENTER: assert property (!TEST_ACTIVE && TEST_REQ && !HARD_RESET_DET && TEST_MODE == `MODE_CARR2
		|=> TEST_ACTIVE && ACTIVE_MODE == `MODE_CARR2) else $error("entry not taken");
	AST_HRST: assert property (TEST_ACTIVE && HARD_RESET_DET |=> !TEST_ACTIVE)
		else $error("hard reset did not end test");
	AST_CARR0: assert property (TX_EN && TEST_ACTIVE && ACTIVE_MODE == `MODE_CARR0 |-> !TX_BIT)
		else $error("carrier 0 sent a one");
	AST_CARR1: assert property (TX_EN && TEST_ACTIVE && ACTIVE_MODE == `MODE_CARR1 |-> TX_BIT)
		else $error("carrier 1 sent a zero");
	AST_TALLY_STEP: assert property ($changed(SELFTEST_ERROR_TALLY) |-> SELFTEST_ERROR_TALLY == 16'h0
		|| SELFTEST_ERROR_TALLY == $past(SELFTEST_ERROR_TALLY) + 16'h1) else $error("tally jumped");
	AST_TALLY_CAUSE: assert property (SELFTEST_ERROR_TALLY == $past(SELFTEST_ERROR_TALLY) + 16'h1
		|-> $past(RX_BIT_STB && RX_PAYLOAD)) else $error("tally grew without a payload bit");
	AST_CONF: assert property (CONFIDENCE_MET |-> FRAME_COUNT >= MIN_TEST_FRAME_COUNT)
		else $error("confidence flagged early");
	AST_HRSEND: assert property (HARD_RESET_SEND |-> FRAME_COUNT == MIN_TEST_FRAME_COUNT
		&& !TX_EN && !TEST_ACTIVE ##1 !HARD_RESET_SEND) else $error("hard reset request misplaced");
	AST_TXEN_IDLE: assert property (!TEST_ACTIVE [*3] |-> !TX_EN)
		else $error("transmit outside test mode");
endmodule
bind pd_phy_bist_pattern_unit pd_bist_asserts #(.MIN_TEST_FRAME_COUNT(MIN_TEST_FRAME_COUNT)) u_asrt (
	.CLK_SYS, .RST, .TEST_REQ, .TEST_MODE, .HARD_RESET_DET, .RX_BIT, .RX_BIT_STB, .RX_PAYLOAD,
	.TX_BIT, .TX_EN, .HARD_RESET_SEND, .TEST_ACTIVE, .ACTIVE_MODE, .FRAME_COUNT,
	.CONFIDENCE_MET, .SELFTEST_ERROR_TALLY);
`default_nettype wire

// file: verification/pd_phy_bist_pattern_unit_tb.sv
// self-checking bench for the self-test pattern unit
`timescale 1ns/1ps
`default_nettype none
module pd_phy_bist_pattern_unit_tb;
	logic clk = 1'b0, rst = 1'b1, req = 1'b0, hrd = 1'b0, err = 1'b0, go = 1'b0;
	logic [2:0] mode = 3'h0;
	wire tx_bit, tx_en, hrs, act, conf, rx_bit, stb;
	wire [2:0] amode;
	wire [15:0] fcnt, tally;
	logic [7:0] r = 8'h34, s = 8'hFF, sr = 8'hFF;
	integer miscompares = 0, n_tests = 0, exp_err = 0, i, k;
	always #10 clk = ~clk;
	pd_phy_bist_pattern_unit #(.MIN_TEST_FRAME_COUNT(16'h2), .BIT_DIV(16'h4)) u_pd_phy_bist_pattern_unit (
		.CLK_SYS(clk), .RST(rst), .TEST_REQ(req), .TEST_MODE(mode), .HARD_RESET_DET(hrd),
		.RX_BIT(rx_bit), .RX_BIT_STB(stb), .RX_PAYLOAD(go), .TX_BIT(tx_bit), .TX_EN(tx_en),
		.HARD_RESET_SEND(hrs), .TEST_ACTIVE(act), .ACTIVE_MODE(amode), .FRAME_COUNT(fcnt),
		.CONFIDENCE_MET(conf), .SELFTEST_ERROR_TALLY(tally));
	pd_tester_model u_pd_tester_model (.clk(clk), .go(go), .err(err), .rx_bit(rx_bit), .rx_stb(stb));
	function automatic logic [7:0] step(input logic [7:0] v);
		step = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic xbit(input logic [2:0] m, input integer n);
		integer p;
		logic [19:0] sop;
		p = n % 1108;
		sop = 20'h8E318;
		xbit = 1'b0;
		case (m)
			3'h1: if (p < 64) xbit = p[0];
				else if (p < 84) xbit = sop[p - 64];
				else begin xbit = s[7]; s = step(s); end
			3'h2: begin xbit = s[7]; s = step(s); end
			3'h4: xbit = 1'b1;
			3'h5: xbit = ~n[0];
			3'h6: xbit = ~n[4];
			default: xbit = 1'b0;
		endcase
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		n_tests++;
		if (got !== want) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches %0d of %0d checks", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic enter(input logic [2:0] m);
		@(negedge clk);
		req = 1'b1; mode = m; go = (m == 3'h0);
		@(negedge clk);
		req = 1'b0; s = 8'hFF; sr = 8'hFF;
		chk(act, 1'b1);
		chk(amode, m);
	endtask
	// bench reference of the receive checker
	always @(posedge clk)
		if (stb && go && act) begin
			if (rx_bit !== sr[7]) exp_err++;
			sr <= step(sr);
		end
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk(act, 1'b0);
		chk(tally, 16'h0);
		chk(fcnt, 16'h0);
		enter(3'h0);
		repeat (600) begin
			@(negedge clk);
			r = step(r);
			err = (r[1:0] == 2'h0);
		end
		chk(tally, exp_err[15:0]);
		hrd = 1'b1;
		@(negedge clk);
		hrd = 1'b0; go = 1'b0;
		chk(act, 1'b0);
		for (int m = 1; m < 7; m++) begin
			enter(m[2:0]);
			for (k = 0; k < 50 && tx_en !== 1'b1; k++) @(negedge clk);
			chk(tx_en, 1'b1);
			if (tx_en !== 1'b1) break;
			for (i = 0; i < (m == 1 ? 2216 : 40); i++) begin
				if (i > 0) repeat (4) @(negedge clk);
				chk(tx_bit, xbit(m[2:0], i));
			end
			if (m == 1) begin
				for (k = 0; k < 30 && hrs !== 1'b1; k++) @(negedge clk);
				chk(hrs, 1'b1);
				chk(fcnt, 16'h2);
				chk(conf, 1'b1);
			end else begin
				req = 1'b1; mode = 3'h0;
				@(negedge clk);
				req = 1'b0; hrd = 1'b1;
				chk(amode, m[2:0]);
				@(negedge clk);
				hrd = 1'b0;
				chk(act, 1'b0);
			end
		end
		give_verdict;
	end
endmodule
`default_nettype wire

// file: verification/pd_tester_model.sv
// far-side tester model feeding pseudo-random payload bits
`timescale 1ns/1ps
`default_nettype none
module pd_tester_model (
	// control
	input  wire logic clk,
	input  wire logic go,
	input  wire logic err,
	// receive stream
	output var  logic rx_bit = 1'b0,
	output var  logic rx_stb = 1'b0
);
	// test data messages are protocol traffic this unit never sees
	logic [7:0] s_q = 8'hFF;
	logic [1:0] n_q = 2'h0;
	always @(posedge clk) begin
		rx_stb <= go && n_q == 2'h3;
		n_q <= go ? n_q + 2'h1 : 2'h0;
		if (!go)
			s_q <= 8'hFF;
		if (go && n_q == 2'h3) begin
			rx_bit <= s_q[7] ^ err;
			s_q <= {s_q[6:0], s_q[7] ^ s_q[5] ^ s_q[4] ^ s_q[3]};
		end else
			rx_bit <= ~rx_bit;
	end
endmodule
`default_nettype wire
